// >>> rtl/rafm_pkg.sv
package rafm_pkg;

  // ***********************************************
  // sizes
  // ***********************************************
  localparam int DATA_W_DEF = 24;
  localparam int NUM_FUNC_DEF = 4;
  localparam int AVG_MAX = 100;
  localparam int MED_RANK_MIN = 1;
  localparam int MED_RANK_MAX = 5;
  localparam int PCT_MAX = 100;
  localparam int REG_AW = 8;
  localparam logic [7:0] PCT_SCALE = 8'h64;

  // ***********************************************
  // register offsets
  // ***********************************************
  localparam logic [REG_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [REG_AW-1:0] REG_CFG_SEL = 8'h04;
  localparam logic [REG_AW-1:0] REG_CFG = 8'h08;
  localparam logic [REG_AW-1:0] REG_STATUS = 8'h0c;

  // ***********************************************
  // field positions
  // ***********************************************
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_TOGGLE_BIT = 1;
  localparam int CTRL_FUNC_LSB = 8;
  localparam int CFG_TYPE_LSB = 0;
  localparam int CFG_MODE_BIT = 2;
  localparam int CFG_MED_EN_BIT = 3;
  localparam int CFG_RANK_LSB = 4;
  localparam int CFG_COUNT_LSB = 8;
  localparam int CFG_PCT_LSB = 16;
  localparam int STAT_EN_BIT = 0;
  localparam int STAT_AFILL_LSB = 8;
  localparam int STAT_MFILL_LSB = 16;
  localparam int STAT_FUNC_LSB = 24;

  // ***********************************************
  // reset values
  // ***********************************************
  localparam logic [6:0] CNT_RST = 7'h01;
  localparam logic [2:0] RANK_RST = 3'h1;
  localparam logic [6:0] PCT_RST = 7'h00;

  typedef enum logic [1:0] {
    avg_none = 2'h0,
    avg_plain = 2'h1,
    windowed_average_type = 2'h2
  } rafm_avg_e;

endpackage

// >>> rtl/rafm_filter.sv
// The register addresses and register access over Wishbone were decided locally.
`timescale 1ns/1ps
// Summary of operation
// R1: median and averaging stages may both be active; output reflects all enabled stages.
// R2: toggle command flips filter enable; enabled uses active function's stored configuration.
// R3: averaging none and median off: enabled filter passes readings unchanged.
// R4: only primary readings are filtered; secondary readings bypass both stages.
// R5: both averaging types output the mean of 1 to 100 conversions.
// R6: windowed type takes a noise window of 0 to 100 percent of range.
// R7: window is a symmetric band around the first conversion in the stack.
// R8: conversion outside window floods the stack, is output, and restarts averaging; in repeating mode the stack is emptied instead.
// R9: inside the window, windowed averaging equals plain averaging.
// R10: moving mode stack is first-in first-out, oldest conversion discarded.
// R11: moving mode gives one output per conversion once the stack is full.
// R12: repeating mode averages a full group once, clears, then starts again.
// R13: one averaging count is shared by plain and windowed types.
// R14: median uses rank 1 to 5 over the latest 2R+1 readings.
// R15: median outputs the middle value of the ascending ordered set.
// R16: median set slides: newest reading replaces oldest, median recomputed.
// R17: each measurement function keeps its own complete filter configuration.
// R18: averaging type offers none, plain and windowed; none does no averaging.
// R19: median has its own enable with rank; disabled median is bypassed.
// R20: with both active, median output feeds the averaging stack.
// R21: configuration or function change clears averaging stack and median set.
module rafm_filter #(
  parameter int DATA_W = rafm_pkg::DATA_W_DEF,
  parameter int NUM_FUNC = rafm_pkg::NUM_FUNC_DEF
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [rafm_pkg::REG_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // reading conversions in
  input wire logic rdg_valid,
  input wire logic rdg_primary,
  input wire logic signed [DATA_W-1:0] rdg_data,
  input wire logic [DATA_W-1:0] rdg_range_fs,
  // filtered readings out
  output logic out_valid,
  output logic signed [DATA_W-1:0] out_data,
  output logic filter_on_indicator
);
  import rafm_pkg::*;

  localparam int CW = 7;
  localparam int SW = DATA_W + CW + 1;
  localparam int FW = (NUM_FUNC > 1) ? $clog2(NUM_FUNC) : 1;
  localparam int MED_N = 2 * MED_RANK_MAX + 1;

  if (NUM_FUNC < 2 || NUM_FUNC > 256 || DATA_W < 8 || DATA_W > 32) begin : g_chk
    $error("rafm_filter: unsupported NUM_FUNC or DATA_W");
  end

  function automatic logic [6:0] clamp7(input logic [7:0] v, input int lo, input int hi);
    logic [6:0] r;
    r = v[6:0];
    if (int'(v) < lo) r = 7'(lo);
    if (int'(v) > hi) r = 7'(hi);
    return r;
  endfunction

  function automatic logic signed [DATA_W-1:0] avg_div(input logic signed [SW-1:0] s,
                                                       input logic [CW-1:0] n);
    logic signed [SW-1:0] q;
    q = s / $signed({{(SW-CW){1'b0}}, n});
    return q[DATA_W-1:0];
  endfunction

  // ***********************************************
  // register bus
  // ***********************************************
  logic wb_ack_q;
  logic [31:0] wb_dat_q;
  logic wb_req;
  logic wr_ctrl;
  logic wr_cfg;
  logic en_q;
  logic [FW-1:0] func_q;
  logic [FW-1:0] sel_q;
  logic [1:0] c_type_q [NUM_FUNC];
  logic c_mode_q [NUM_FUNC];
  logic c_med_q [NUM_FUNC];
  logic [2:0] c_rank_q [NUM_FUNC];
  logic [CW-1:0] c_cnt_q [NUM_FUNC];
  logic [6:0] c_pct_q [NUM_FUNC];
  logic flush;
  logic [CW-1:0] a_fill_q;
  logic [3:0] m_fill_q;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_q;
  assign wr_ctrl = wb_req & wb_we_i & (wb_adr_i == REG_CTRL);
  assign wr_cfg = wb_req & wb_we_i & (wb_adr_i == REG_CFG);
  assign wb_ack_o = wb_ack_q;
  assign wb_dat_o = wb_dat_q;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      wb_ack_q <= 1'b0;
    else
      wb_ack_q <= wb_req;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      wb_dat_q <= 32'h0000_0000;
    else if (wb_req && !wb_we_i)
    begin
      wb_dat_q <= 32'h0000_0000;
      case (wb_adr_i)
        REG_CTRL:
        begin
          wb_dat_q[CTRL_EN_BIT] <= en_q;
          wb_dat_q[CTRL_FUNC_LSB +: FW] <= func_q;
        end
        REG_CFG_SEL: wb_dat_q[FW-1:0] <= sel_q;
        REG_CFG:
        begin
          wb_dat_q[CFG_TYPE_LSB +: 2] <= c_type_q[sel_q];
          wb_dat_q[CFG_MODE_BIT] <= c_mode_q[sel_q];
          wb_dat_q[CFG_MED_EN_BIT] <= c_med_q[sel_q];
          wb_dat_q[CFG_RANK_LSB +: 3] <= c_rank_q[sel_q];
          wb_dat_q[CFG_COUNT_LSB +: CW] <= c_cnt_q[sel_q];
          wb_dat_q[CFG_PCT_LSB +: 7] <= c_pct_q[sel_q];
        end
        REG_STATUS:
        begin
          wb_dat_q[STAT_EN_BIT] <= en_q;
          wb_dat_q[STAT_AFILL_LSB +: CW] <= a_fill_q;
          wb_dat_q[STAT_MFILL_LSB +: 4] <= m_fill_q;
          wb_dat_q[STAT_FUNC_LSB +: FW] <= func_q;
        end
        default: wb_dat_q <= 32'h0000_0000;
      endcase
    end
  end

  // R2: toggle flips enable
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      en_q <= 1'b0;
    else if (wr_ctrl && wb_sel_i[0] && wb_dat_i[CTRL_TOGGLE_BIT])
      en_q <= ~en_q;
  end

  // out-of-range function numbers are ignored so no stale config is selected
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      func_q <= '0;
    else if (wr_ctrl && wb_sel_i[1] && int'(wb_dat_i[CTRL_FUNC_LSB +: 8]) < NUM_FUNC)
      func_q <= wb_dat_i[CTRL_FUNC_LSB +: FW];
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      sel_q <= '0;
    else if (wb_req && wb_we_i && wb_adr_i == REG_CFG_SEL && wb_sel_i[0]
             && int'(wb_dat_i[7:0]) < NUM_FUNC)
      sel_q <= wb_dat_i[FW-1:0];
  end

  // R17: per-function configuration, R13: one count for both types
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      for (int f = 0; f < NUM_FUNC; f++)
      begin
        c_type_q[f] <= avg_none;
        c_mode_q[f] <= 1'b0;
        c_med_q[f] <= 1'b0;
        c_rank_q[f] <= RANK_RST;
        c_cnt_q[f] <= CNT_RST;
        c_pct_q[f] <= PCT_RST;
      end
    end
    else if (wr_cfg)
    begin
      if (wb_sel_i[0])
      begin
        // R18: reserved type code falls back to none
        c_type_q[sel_q] <= (wb_dat_i[CFG_TYPE_LSB +: 2] == 2'h3) ? avg_none
                           : wb_dat_i[CFG_TYPE_LSB +: 2];
        c_mode_q[sel_q] <= wb_dat_i[CFG_MODE_BIT];
        c_med_q[sel_q] <= wb_dat_i[CFG_MED_EN_BIT];
        // R14: rank held within 1 to 5
        c_rank_q[sel_q] <= 3'(clamp7({5'h00, wb_dat_i[CFG_RANK_LSB +: 3]},
                                     MED_RANK_MIN, MED_RANK_MAX));
      end
      // R5: count held within 1 to 100
      if (wb_sel_i[1])
        c_cnt_q[sel_q] <= clamp7(wb_dat_i[CFG_COUNT_LSB +: 8], 1, AVG_MAX);
      // R6: window held within 0 to 100 percent
      if (wb_sel_i[2])
        c_pct_q[sel_q] <= clamp7(wb_dat_i[CFG_PCT_LSB +: 8], 0, PCT_MAX);
    end
  end

  // R21: clear stages on active function's config write, or on any control write (function or enable)
  assign flush = (wr_cfg && sel_q == func_q) || wr_ctrl;

  // ***********************************************
  // active settings
  // ***********************************************
  logic avg_on;
  logic med_on;
  logic mode_rep;
  logic [CW-1:0] n_cnt;
  logic [3:0] m_n;
  logic [2:0] rank;
  logic in_take;

  assign avg_on = en_q && (c_type_q[func_q] != avg_none);
  // R19: median own enable
  assign med_on = en_q && c_med_q[func_q];
  assign mode_rep = c_mode_q[func_q];
  assign n_cnt = c_cnt_q[func_q];
  assign rank = c_rank_q[func_q];
  assign m_n = {rank, 1'b1};
  // R4: secondary readings are never taken by the stages
  assign in_take = rdg_valid && rdg_primary && (avg_on || med_on);

  // ***********************************************
  // median stage
  // ***********************************************
  logic signed [DATA_W-1:0] m_set_q [MED_N];
  logic [3:0] m_ptr_q;
  logic m_fire_q;
  logic signed [DATA_W-1:0] m_val;

  // R16: newest replaces oldest
  always_ff @(posedge clk_sys)
  begin
    if (srst || flush)
    begin
      m_ptr_q <= 4'h0;
      m_fill_q <= 4'h0;
      m_fire_q <= 1'b0;
    end
    else
    begin
      m_fire_q <= 1'b0;
      if (in_take && med_on)
      begin
        m_set_q[m_ptr_q] <= rdg_data;
        m_ptr_q <= (m_ptr_q == m_n - 4'h1) ? 4'h0 : m_ptr_q + 4'h1;
        if (m_fill_q != m_n)
          m_fill_q <= m_fill_q + 4'h1;
        m_fire_q <= (m_fill_q + 4'h1 >= m_n);
      end
    end
  end

  // R15: value with at most R smaller and more than R smaller-or-equal
  always_comb
  begin
    logic [3:0] lt;
    logic [3:0] le;
    lt = 4'h0;
    le = 4'h0;
    m_val = m_set_q[0];
    for (int i = 0; i < MED_N; i++)
    begin
      lt = 4'h0;
      le = 4'h0;
      for (int j = 0; j < MED_N; j++)
      begin
        if (j < int'(m_n) && m_set_q[j] < m_set_q[i])
          lt = lt + 4'h1;
        if (j < int'(m_n) && m_set_q[j] <= m_set_q[i])
          le = le + 4'h1;
      end
      if (i < int'(m_n) && lt <= {1'b0, rank} && le > {1'b0, rank})
        m_val = m_set_q[i];
    end
  end

  // ***********************************************
  // averaging stage
  // ***********************************************
  logic signed [DATA_W-1:0] a_stk_q [AVG_MAX];
  logic [CW-1:0] a_ptr_q;
  logic signed [SW-1:0] a_sum_q;
  logic a_in_v;
  logic signed [DATA_W-1:0] a_in_x;
  logic signed [DATA_W-1:0] a_ref;
  logic signed [SW-1:0] a_sum_add;
  logic signed [SW-1:0] a_sum_mov;
  logic [SW+7:0] a_lhs;
  logic [SW+7:0] a_rhs;
  logic signed [SW-1:0] a_diff;
  logic a_oow;
  logic a_full;
  logic avg_v;
  logic signed [DATA_W-1:0] avg_x;

  // R20: median output feeds averaging when both are on
  assign a_in_v = avg_on && (med_on ? m_fire_q : in_take);
  assign a_in_x = med_on ? m_val : rdg_data;
  assign a_full = (a_fill_q == n_cnt);
  // R7: reference is the oldest conversion held
  assign a_ref = a_full ? a_stk_q[a_ptr_q] : a_stk_q[0];
  assign a_sum_add = a_sum_q + SW'(a_in_x);
  assign a_sum_mov = a_sum_add - SW'(a_ref);
  assign a_diff = SW'(a_in_x) - SW'(a_ref);
  assign a_lhs = (SW+8)'(a_diff < 0 ? -a_diff : a_diff) * (SW+8)'(PCT_SCALE);
  assign a_rhs = (SW+8)'(rdg_range_fs) * (SW+8)'(c_pct_q[func_q]);
  // R6: window test only for the windowed type with a non-empty stack
  assign a_oow = (c_type_q[func_q] == windowed_average_type) && (a_fill_q != '0)
                 && (a_lhs > a_rhs);

  // R9: same mean inside window
  always_comb
  begin
    avg_v = 1'b0;
    avg_x = a_in_x;
    if (a_in_v)
    begin
      if (a_oow)
        avg_v = 1'b1;
      else if (!mode_rep)
      begin
        // R11: one output per conversion once full
        avg_v = a_full || (a_fill_q + 7'h01 == n_cnt);
        avg_x = avg_div(a_full ? a_sum_mov : a_sum_add, n_cnt);
      end
      else
      begin
        avg_v = (a_fill_q + 7'h01 == n_cnt);
        avg_x = avg_div(a_sum_add, n_cnt);
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst || flush)
    begin
      a_fill_q <= '0;
      a_ptr_q <= '0;
      a_sum_q <= '0;
    end
    else if (a_in_v)
    begin
      if (a_oow)
      begin
        // R8: moving mode floods stack and restarts from this conversion; repeating mode empties it
        a_ptr_q <= '0;
        if (!mode_rep)
        begin
          for (int k = 0; k < AVG_MAX; k++)
            a_stk_q[k] <= a_in_x;
          a_fill_q <= n_cnt;
          a_sum_q <= SW'(a_in_x) * $signed({1'b0, n_cnt});
        end
        else
        begin
          a_fill_q <= '0;
          a_sum_q <= '0;
        end
      end
      else if (!mode_rep)
      begin
        // R10: oldest slot overwritten
        a_stk_q[a_ptr_q] <= a_in_x;
        a_ptr_q <= (a_ptr_q + 7'h01 == n_cnt) ? '0 : a_ptr_q + 7'h01;
        a_sum_q <= a_full ? a_sum_mov : a_sum_add;
        if (!a_full)
          a_fill_q <= a_fill_q + 7'h01;
      end
      else if (a_fill_q + 7'h01 == n_cnt)
      begin
        // R12: group complete, stack flushed
        a_fill_q <= '0;
        a_ptr_q <= '0;
        a_sum_q <= '0;
      end
      else
      begin
        a_stk_q[a_ptr_q] <= a_in_x;
        a_ptr_q <= a_ptr_q + 7'h01;
        a_fill_q <= a_fill_q + 7'h01;
        a_sum_q <= a_sum_add;
      end
    end
  end

  // ***********************************************
  // output
  // ***********************************************
  logic out_valid_q;
  logic signed [DATA_W-1:0] out_data_q;

  assign out_valid = out_valid_q;
  assign out_data = out_data_q;
  assign filter_on_indicator = en_q;

  // R1: final reading comes from the last enabled stage
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end
    else
    begin
      out_valid_q <= 1'b0;
      if (avg_v)
      begin
        out_valid_q <= 1'b1;
        out_data_q <= avg_x;
      end
      else if (m_fire_q && med_on && !avg_on)
      begin
        out_valid_q <= 1'b1;
        out_data_q <= m_val;
      end
      // R3: untaken readings pass unchanged
      else if (rdg_valid && !in_take)
      begin
        out_valid_q <= 1'b1;
        out_data_q <= rdg_data;
      end
    end
  end

  // ***********************************************
  // assertions
  // ***********************************************
  a_ack_single: assert property (@(posedge clk_sys) disable iff (srst)
    wb_ack_q |=> !wb_ack_q) else $error("ack held longer than one cycle");
  a_ack_answer: assert property (@(posedge clk_sys) disable iff (srst)
    wb_req |=> wb_ack_q) else $error("bus request not answered");
  a_toggle_flip: assert property (@(posedge clk_sys) disable iff (srst) // R2
    wr_ctrl && wb_sel_i[0] && wb_dat_i[CTRL_TOGGLE_BIT] |=> en_q != $past(en_q))
    else $error("toggle did not flip enable");
  a_secondary_bypass: assert property (@(posedge clk_sys) disable iff (srst) // R4
    rdg_valid && !rdg_primary && !avg_v && !(m_fire_q && med_on)
    |=> out_valid_q && out_data_q == $past(rdg_data))
    else $error("secondary reading not passed through");
  a_no_filter_pass: assert property (@(posedge clk_sys) disable iff (srst) // R3
    rdg_valid && !avg_on && !med_on |=> out_valid_q && out_data_q == $past(rdg_data))
    else $error("reading altered with no stage active");
  a_flood_out: assert property (@(posedge clk_sys) disable iff (srst || flush) // R8
    a_in_v && a_oow |=> out_valid_q && out_data_q == $past(a_in_x))
    else $error("out-of-window conversion not output as is");
  a_flood_fill: assert property (@(posedge clk_sys) disable iff (srst || flush) // R8
    a_in_v && a_oow && !mode_rep |=> a_fill_q == $past(n_cnt))
    else $error("stack not flooded");
  a_repeat_clear: assert property (@(posedge clk_sys) disable iff (srst || flush) // R12
    a_in_v && !a_oow && mode_rep && a_fill_q + 7'h01 == n_cnt |=> a_fill_q == '0 && out_valid_q)
    else $error("repeating group not output and cleared");
  a_fill_bound: assert property (@(posedge clk_sys) disable iff (srst) // R10
    a_fill_q <= n_cnt && m_fill_q <= m_n) else $error("stage fill beyond setting");
  a_med_rank: assert property (@(posedge clk_sys) disable iff (srst) // R14
    rank >= 3'(MED_RANK_MIN) && rank <= 3'(MED_RANK_MAX)) else $error("rank out of bounds");

endmodule

// >>> sim/rafm_conv_model.sv
`timescale 1ns/1ps
// ***********************************************
// measurement converter model
// ***********************************************
module rafm_conv_model #(
  parameter int DATA_W = 24
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // bench commands
  input wire logic send,
  input wire logic send_primary,
  input wire logic [DATA_W-1:0] send_data,
  input wire logic [DATA_W-1:0] range_in,
  // converter outputs
  output logic rdg_valid,
  output logic rdg_primary,
  output logic [DATA_W-1:0] rdg_data,
  output logic [DATA_W-1:0] rdg_range_fs
);
  // idle cycles scramble the data so a stale value never passes for a reading
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      rdg_valid <= 1'b0;
      rdg_primary <= 1'b0;
      rdg_data <= '0;
    end
    else if (send)
    begin
      rdg_valid <= 1'b1;
      rdg_primary <= send_primary;
      rdg_data <= send_data;
    end
    else
    begin
      rdg_valid <= 1'b0;
      rdg_primary <= ~rdg_primary;
      rdg_data <= ~rdg_data;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    rdg_range_fs <= range_in;
  end
endmodule

// >>> sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import rafm_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [REG_AW-1:0] adr = '0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic send = 1'b0;
  logic send_primary = 1'b0;
  logic [23:0] send_data = 24'h0;
  logic [23:0] range_in = 24'h0003e8;
  logic rdg_valid;
  logic rdg_primary;
  logic [23:0] rdg_data;
  logic [23:0] rdg_range_fs;
  logic out_valid;
  logic signed [23:0] out_data;
  logic filter_on_indicator;
  logic [23:0] out_last = 24'h0;
  int bad_count = 0;
  int samples_checked = 0;
  int out_n = 0;

  always #10 clk_sys = ~clk_sys;

  rafm_conv_model #(.DATA_W(24)) i_conv (.clk_sys(clk_sys), .srst(srst), .send(send),
    .send_primary(send_primary), .send_data(send_data), .range_in(range_in),
    .rdg_valid(rdg_valid), .rdg_primary(rdg_primary), .rdg_data(rdg_data),
    .rdg_range_fs(rdg_range_fs));

  rafm_filter #(.DATA_W(24), .NUM_FUNC(4)) i_dut (.clk_sys(clk_sys), .srst(srst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rdg_valid(rdg_valid),
    .rdg_primary(rdg_primary), .rdg_data(rdg_data), .rdg_range_fs(rdg_range_fs),
    .out_valid(out_valid), .out_data(out_data), .filter_on_indicator(filter_on_indicator));

  always @(posedge clk_sys)
  begin
    if (out_valid === 1'b1)
    begin
      out_n++;
      out_last = out_data;
    end
  end

  // ***********************************************
  // shared tasks
  // ***********************************************
  task automatic finish_test;
    $display("checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n < 20)
      @(posedge clk_sys);
    else
    begin
      bad_count++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, s, d, q);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 4'hf, 32'h0, q);
    chk_val(q, e);
  endtask

  task automatic cfg(input logic [7:0] f, input logic [1:0] ty, input logic md,
                     input logic me, input logic [2:0] rk, input logic [6:0] cn,
                     input logic [6:0] pc);
    wr(REG_CFG_SEL, 4'hf, {24'h0, f});
    wr(REG_CFG, 4'hf, {9'h0, pc, 1'b0, cn, 1'b0, rk, me, md, ty});
  endtask

  // readings stay at least six cycles apart, wider than the minimum spacing
  task automatic rd(input logic [23:0] v, input logic p, input int n_exp, input logic [23:0] e);
    int n0;
    n0 = out_n;
    send <= 1'b1;
    send_primary <= p;
    send_data <= v;
    @(posedge clk_sys);
    send <= 1'b0;
    repeat (5) @(posedge clk_sys);
    chk_val(out_n - n0, n_exp);
    if (n_exp > 0)
      chk_val({8'h00, out_last}, {8'h00, e});
  endtask

  // ***********************************************
  // scenarios
  // ***********************************************
  task automatic t_regs;
    chk_val({31'h0, filter_on_indicator}, 32'h0);
    rdchk(REG_CTRL, 32'h0);
    rdchk(REG_CFG, 32'h00000110);
    rdchk(8'h10, 32'h0);
    cfg(8'h00, 2'h3, 1'b0, 1'b0, 3'h7, 7'h7f, 7'h7f);
    rdchk(REG_CFG, 32'h00646450);
    cfg(8'h00, 2'h0, 1'b0, 1'b0, 3'h0, 7'h00, 7'h00);
    rdchk(REG_CFG, 32'h00000110);
    $display("test regs done");
  endtask

  task automatic t_toggle;
    wr(REG_CTRL, 4'h1, 32'h2);
    chk_val({31'h0, filter_on_indicator}, 32'h1);
    rdchk(REG_CTRL, 32'h1);
    wr(REG_CTRL, 4'h1, 32'h2);
    chk_val({31'h0, filter_on_indicator}, 32'h0);
    wr(REG_CTRL, 4'h1, 32'h2);
    rd(24'h0004d2, 1'b1, 1, 24'h0004d2);
    $display("test toggle done");
  endtask

  task automatic t_moving;
    cfg(8'h00, 2'h1, 1'b0, 1'b0, 3'h1, 7'h03, 7'h00);
    rd(24'd10, 1'b1, 0, 24'h0);
    rd(24'd77, 1'b0, 1, 24'd77);
    rd(24'd20, 1'b1, 0, 24'h0);
    rd(24'd30, 1'b1, 1, 24'd20);
    rd(24'd60, 1'b1, 1, 24'd36);
    $display("test moving done");
  endtask

  task automatic t_repeat;
    cfg(8'h00, 2'h1, 1'b1, 1'b0, 3'h1, 7'h02, 7'h00);
    rd(24'd10, 1'b1, 0, 24'h0);
    rd(24'd20, 1'b1, 1, 24'd15);
    rd(24'd40, 1'b1, 0, 24'h0);
    rd(24'd50, 1'b1, 1, 24'd45);
    $display("test repeat done");
  endtask

  task automatic t_window;
    cfg(8'h00, 2'h2, 1'b0, 1'b0, 3'h1, 7'h02, 7'd10);
    rd(24'd100, 1'b1, 0, 24'h0);
    rd(24'd150, 1'b1, 1, 24'd125);
    rd(24'd180, 1'b1, 1, 24'd165);
    rd(24'd900, 1'b1, 1, 24'd900);
    rd(24'd910, 1'b1, 1, 24'd905);
    cfg(8'h00, 2'h2, 1'b1, 1'b0, 3'h1, 7'h02, 7'd10);
    rd(24'd100, 1'b1, 0, 24'h0);
    rd(24'd500, 1'b1, 1, 24'd500);
    rd(24'd200, 1'b1, 0, 24'h0);
    rd(24'd210, 1'b1, 1, 24'd205);
    $display("test window done");
  endtask

  task automatic t_median;
    cfg(8'h00, 2'h0, 1'b0, 1'b1, 3'h1, 7'h01, 7'h00);
    rd(24'd5, 1'b1, 0, 24'h0);
    rd(24'd1, 1'b1, 0, 24'h0);
    rd(24'd3, 1'b1, 1, 24'd3);
    rd(24'd2, 1'b1, 1, 24'd2);
    cfg(8'h00, 2'h0, 1'b0, 1'b1, 3'h2, 7'h01, 7'h00);
    rd(24'd9, 1'b1, 0, 24'h0);
    rd(24'd1, 1'b1, 0, 24'h0);
    rd(24'd7, 1'b1, 0, 24'h0);
    rd(24'd3, 1'b1, 0, 24'h0);
    rd(24'd5, 1'b1, 1, 24'd5);
    rd(24'd2, 1'b1, 1, 24'd3);
    cfg(8'h00, 2'h0, 1'b0, 1'b0, 3'h1, 7'h01, 7'h00);
    rd(24'd9, 1'b1, 1, 24'd9);
    $display("test median done");
  endtask

  task automatic t_both;
    cfg(8'h00, 2'h1, 1'b0, 1'b1, 3'h1, 7'h02, 7'h00);
    rd(24'd10, 1'b1, 0, 24'h0);
    rd(24'd20, 1'b1, 0, 24'h0);
    rd(24'd30, 1'b1, 0, 24'h0);
    rd(24'd40, 1'b1, 1, 24'd25);
    $display("test both done");
  endtask

  task automatic t_func;
    cfg(8'h00, 2'h1, 1'b0, 1'b0, 3'h1, 7'h02, 7'h00);
    rd(24'd10, 1'b1, 0, 24'h0);
    cfg(8'h00, 2'h1, 1'b0, 1'b0, 3'h1, 7'h02, 7'h00);
    rd(24'd20, 1'b1, 0, 24'h0);
    rd(24'd30, 1'b1, 1, 24'd25);
    cfg(8'h01, 2'h1, 1'b0, 1'b0, 3'h1, 7'h05, 7'h00);
    rdchk(REG_CFG, 32'h00000511);
    rdchk(REG_CFG_SEL, 32'h00000001);
    wr(REG_CFG_SEL, 4'hf, 32'h0);
    rdchk(REG_CFG, 32'h00000211);
    wr(REG_CTRL, 4'h2, 32'h00000100);
    rdchk(REG_STATUS, 32'h01000001);
    rd(24'd10, 1'b1, 0, 24'h0);
    $display("test func done");
  endtask

  initial
  begin
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    t_regs();
    t_toggle();
    t_moving();
    t_repeat();
    t_window();
    t_median();
    t_both();
    t_func();
    finish_test();
  end
endmodule
